// *** rtl/mmr_agent.sv ***
`default_nettype none

`include "mmr_defs.svh"

module mmr_agent import mmr_pkg::*; #(
   parameter int DATA_W = `MMR_DATA_W,
   parameter int ADDR_W = `MMR_ADDR_W,
   parameter int DEPTH = `MMR_DEPTH,
   parameter int ROM_WORDS = `MMR_ROM_WORDS,
   parameter int BURST_W = `MMR_BURST_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Host request
   input wire logic [ADDR_W-1:0] address,
   input wire logic [DATA_W/`MMR_LANE_W-1:0] byteenable,
   input wire logic read,
   input wire logic write,
   input wire logic [DATA_W-1:0] writedata,
   input wire logic [BURST_W-1:0] burstcount,
   input wire logic rom_write_ovr,
   // Agent answer
   output logic waitrequest,
   output logic [DATA_W-1:0] readdata,
   output mmr_rsp_t rsp
);

   // ==========================================
   // Geometry
   // Payload width must lie in 8..1024 and be a whole number of lanes
   localparam int LANES = DATA_W / `MMR_LANE_W;
   localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [ADDR_W:0] DEPTH_L = (ADDR_W + 1)'(DEPTH);
   localparam logic [ADDR_W:0] ROM_L = (ADDR_W + 1)'(ROM_WORDS);
   localparam logic [BURST_W-1:0] ONE_B = BURST_W'(1);

   mmr_state_t state_q;
   logic [ADDR_W-1:0] addr_q;
   logic [BURST_W-1:0] left_q;
   mmr_status_t wr_st_q;
   logic [DATA_W-1:0] readdata_q;
   logic rd_valid_q;
   logic wr_valid_q;
   mmr_status_t status_q;

   logic rd_take;
   logic wr_take;
   logic wr_last;
   logic [BURST_W-1:0] bc_eff;
   logic [ADDR_W-1:0] beat_addr;
   logic [IDX_W-1:0] beat_idx;
   logic beat_mapped;
   logic beat_rom;
   logic wr_allowed;
   logic [DATA_W-1:0] rd_word;
   mmr_status_t beat_wst;
   mmr_status_t beat_rst;
   mmr_status_t wr_st_d;

   // ==========================================
   // Request decode
   // read accepted
   always_comb begin
      rd_take = 1'b0;
      if (state_q == ST_IDLE) begin
         rd_take = read;
      end
   end

   // write beat accepted
   // A read and write together from idle is a host fault; read wins
   always_comb begin
      wr_take = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            wr_take = write && !read;
         end
         ST_WR: begin
            wr_take = write;
         end
         ST_RD: begin
            wr_take = 1'b0;
         end
      endcase
   end

   // Burst length of zero is taken as a single beat
   always_comb begin
      bc_eff = burstcount;
      if (burstcount == '0) begin
         bc_eff = ONE_B;
      end
   end

   // Length comes from the request on the first beat, from the counter later
   always_comb begin
      wr_last = (left_q == ONE_B);
      if (state_q == ST_IDLE) begin
         wr_last = (bc_eff == ONE_B);
      end
   end

   // Reset and the read return stall the host; writes stream at full rate
   assign waitrequest = rst || (state_q == ST_RD);

   // Burst beats after the first ignore the host address
   always_comb begin
      beat_addr = addr_q;
      if (state_q == ST_IDLE) begin
         beat_addr = address;
      end
   end

   assign beat_idx = beat_addr[IDX_W-1:0];
   assign beat_mapped = {1'b0, beat_addr} < DEPTH_L;
   assign beat_rom = {1'b0, beat_addr} < ROM_L;

   assign wr_allowed = beat_mapped && (!beat_rom || rom_write_ovr);

   always_comb begin
      if (!beat_mapped) begin
         beat_wst = status_unmapped_target;
      end else if (!wr_allowed) begin
         beat_wst = status_endpoint_fail;
      end else begin
         beat_wst = status_success;
      end
   end

   always_comb begin
      if (beat_mapped) begin
         beat_rst = status_success;
      end else begin
         beat_rst = status_unmapped_target;
      end
   end

   // Worst code over the burst; OR of the codes keeps unmapped above fail
   always_comb begin
      wr_st_d = mmr_status_t'(wr_st_q | beat_wst);
      if (state_q == ST_IDLE) begin
         wr_st_d = beat_wst;
      end
   end

   // ==========================================
   // Storage, one flop array per byte lane
   genvar l;
   generate
      for (l = 0; l < LANES; l++) begin : g_lane
         logic [`MMR_LANE_W-1:0] lane_q [DEPTH];

         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               for (int i = 0; i < DEPTH; i++) begin
                  lane_q[i] <= '0;
               end
            end else if (wr_take && wr_allowed && byteenable[l]) begin
               lane_q[beat_idx] <= writedata[l*`MMR_LANE_W +: `MMR_LANE_W];
            end
         end

         assign rd_word[l*`MMR_LANE_W +: `MMR_LANE_W] = lane_q[beat_idx];
      end
   endgenerate

   // ==========================================
   // Sequencing
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (rd_take) begin
                  state_q <= ST_RD;
               end else if (wr_take && !wr_last) begin
                  state_q <= ST_WR;
               end
            end
            ST_RD: begin
               if (left_q == ONE_B) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_WR: begin
               if (wr_take && wr_last) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Burst address, incrementing only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         addr_q <= '0;
      end else if (rd_take) begin
         addr_q <= address;
      end else if (wr_take || (state_q == ST_RD)) begin
         addr_q <= beat_addr + ADDR_W'(1);
      end
   end

   // Beats still to come in the burst
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         left_q <= '0;
      end else if (rd_take) begin
         left_q <= bc_eff;
      end else if (wr_take && (state_q == ST_IDLE)) begin
         left_q <= bc_eff - ONE_B;
      end else if (wr_take || (state_q == ST_RD)) begin
         left_q <= left_q - ONE_B;
      end
   end

   // Write status gathered over the burst
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_st_q <= status_success;
      end else if (wr_take) begin
         wr_st_q <= wr_st_d;
      end
   end

   // ==========================================
   // Answer channel
   // status rides the read valid strobe
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= (state_q == ST_RD);
      end
   end

   // only once the last beat is taken
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_valid_q <= 1'b0;
      end else begin
         wr_valid_q <= wr_take && wr_last;
      end
   end

   // reads and writes never overlap
   // The state machine keeps the two valid strobes apart by construction
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_q <= status_success;
      end else if (state_q == ST_RD) begin
         status_q <= beat_rst;
      end else if (wr_take && wr_last) begin
         status_q <= wr_st_d;
      end else begin
         status_q <= status_success;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         readdata_q <= '0;
      end else if (state_q == ST_RD) begin
         readdata_q <= beat_mapped ? rd_word : '0;
      end
   end

   assign readdata = readdata_q;
   assign rsp = '{rd_valid: rd_valid_q, wr_valid: wr_valid_q, status: status_q};

endmodule

`default_nettype wire

// *** rtl/mmr_defs.svh ***
`ifndef MMR_DEFS_SVH
`define MMR_DEFS_SVH

// ==========================================
// Status encodings
`define MMR_ST_SUCCESS 2'h0
`define MMR_ST_RESERVED 2'h1
`define MMR_ST_ENDPOINT_FAIL 2'h2
`define MMR_ST_UNMAPPED 2'h3

// ==========================================
// Default geometry
`define MMR_DATA_W 32
`define MMR_DATA_W_MIN 8
`define MMR_DATA_W_MAX 1024
`define MMR_ADDR_W 10
`define MMR_DEPTH 256
`define MMR_ROM_WORDS 64
`define MMR_BURST_W 4
`define MMR_LANE_W 8

`endif

// *** rtl/mmr_pkg.sv ***
`default_nettype none

package mmr_pkg;
`include "mmr_defs.svh"

   // ==========================================
   // Types
   typedef enum logic [1:0] {
      status_success = `MMR_ST_SUCCESS,
      status_endpoint_fail = `MMR_ST_ENDPOINT_FAIL,
      status_unmapped_target = `MMR_ST_UNMAPPED
   } mmr_status_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RD,
      ST_WR
   } mmr_state_t;

   typedef struct packed {
      logic rd_valid;
      logic wr_valid;
      mmr_status_t status;
   } mmr_rsp_t;

endpackage

`default_nettype wire

// *** bench/mmr_monitor.sv ***
`default_nettype none
module mmr_monitor import mmr_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [9:0] address,
   input wire logic [3:0] burstcount,
   input wire logic read,
   input wire logic write,
   input wire logic rom_write_ovr,
   input wire logic waitrequest,
   input wire mmr_rsp_t rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Beat counting
   logic [4:0] n_q, e_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         n_q <= 5'h0;
         e_q <= 5'h0;
      end else begin
         n_q <= waitrequest ? n_q + 5'h1 : 5'h0;
         // Burst length is latched at the take edge, held while busy
         if (!waitrequest) begin
            e_q <= (burstcount == 4'h0) ? 5'h1 : {1'h0, burstcount};
         end
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   excl_valid_a: assert property (!(rsp.rd_valid && rsp.wr_valid))
      else $error("read and write status together");
   no_reserved_a: assert property (rsp.status != 2'h1)
      else $error("reserved status code");
   quiet_status_a: assert property (!(rsp.rd_valid || rsp.wr_valid) |-> rsp.status == 2'h0)
      else $error("status without strobe");
   rd_first_a: assert property ($rose(waitrequest) |-> $past(read) ##1 rsp.rd_valid)
      else $error("read beat missing");
   rd_train_a: assert property (waitrequest && !rst |=> rsp.rd_valid)
      else $error("gap in read beats");
   rd_count_a: assert property ($fell(waitrequest) && !$past(rst) |-> n_q == e_q)
      else $error("read beat count wrong");
   wr_after_a: assert property (rsp.wr_valid |-> $past(write) && !$past(waitrequest))
      else $error("write status too early");
   rom_guard_a: assert property (write && !read && !$past(write) && !waitrequest &&
      burstcount == 4'h1 && address < 10'h40 && !rom_write_ovr |=> rsp.status == 2'h2)
      else $error("read-only write not refused");
   rd_burst_c: cover property (rsp.rd_valid [*3]);
   wr_err_c: cover property (rsp.wr_valid && rsp.status == 2'h3);
   rd_err_c: cover property (rsp.rd_valid && rsp.status == 2'h3);
endmodule
bind mmr_agent mmr_monitor i_mmr_monitor (.*);
`default_nettype wire

// *** bench/mmr_host.sv ***
`default_nettype none
module mmr_host import mmr_pkg::*; (
   input wire logic clk_sys,
   input wire logic waitrequest,
   input wire logic [31:0] readdata,
   input wire mmr_rsp_t rsp,
   output logic [9:0] address,
   output logic [3:0] byteenable,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] burstcount,
   output logic rom_write_ovr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Host requests
   initial {address, byteenable, read, write, writedata, burstcount, rom_write_ovr} = '0;
   task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] n,
      input logic [3:0] be, input logic o, output logic [2:0] r);
      @(posedge clk_sys);
      {address, burstcount, byteenable, rom_write_ovr, write, writedata} <= {a, n, be, o, 1'h1, d};
      for (int i = 1; i <= n; i++) begin
         do @(negedge clk_sys); while (waitrequest);
         @(posedge clk_sys);
         writedata <= d + i;
         write <= (i < n);
      end
      address <= ~a;
      @(negedge clk_sys);
      r = {rsp.wr_valid, rsp.status};
   endtask
   // read held until taken, beats kept whole
   task automatic rd(input logic [9:0] a, input logic [3:0] n, output logic [33:0] q[$]);
      q = {};
      @(posedge clk_sys);
      {address, burstcount, read} <= {a, n, 1'h1};
      do @(negedge clk_sys); while (waitrequest);
      @(posedge clk_sys);
      read <= 1'h0;
      address <= ~a;
      // One cycle for the return latency and one spare so a surplus beat is seen
      repeat (n + 2) begin
         @(negedge clk_sys);
         if (rsp.rd_valid) begin
            q.push_back({rsp.status, readdata});
         end
      end
   endtask
endmodule
`default_nettype wire

// *** bench/mmr_agent_tb.sv ***
`default_nettype none
module mmr_agent_tb import mmr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, read, write, rom_write_ovr, waitrequest;
   logic [9:0] address;
   logic [3:0] byteenable, burstcount;
   logic [31:0] writedata, readdata;
   mmr_rsp_t rsp;
   int n_fail, comparisons;
   logic [2:0] r;
   logic [33:0] q[$];
   initial begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   mmr_agent i_mmr_agent (.*);
   mmr_host i_mmr_host (.*);
   // ==========
   // Checking
   task automatic chk(input string s, input logic [33:0] g, input logic [33:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic t_rom;
      i_mmr_host.wr(10'h5, 32'h1234abcd, 4'h1, 4'hf, 1'h0, r);
      chk("rom blocked", r, 3'h6);
      i_mmr_host.wr(10'h5, 32'h1234abcd, 4'h1, 4'hf, 1'h1, r);
      chk("rom override", r, 3'h4);
      i_mmr_host.wr(10'h5, 32'h0, 4'h1, 4'h6, 1'h1, r);
      i_mmr_host.rd(10'h5, 4'h1, q);
      chk("lane data", q[0], 34'h120000cd);
      $display("t_rom done");
   endtask
   task automatic t_burst;
      i_mmr_host.wr(10'h64, 32'ha0, 4'h3, 4'hf, 1'h0, r);
      chk("burst wstat", r, 3'h4);
      i_mmr_host.rd(10'h64, 4'h3, q);
      chk("beats", q.size(), 34'h3);
      for (int i = 0; i < 3; i++) begin
         chk("beat data", q[i], 34'ha0 + i);
      end
      $display("t_burst done");
   endtask
   task automatic t_err;
      i_mmr_host.wr(10'h12c, 32'h0, 4'h1, 4'hf, 1'h0, r);
      chk("unmapped wstat", r, 3'h7);
      i_mmr_host.rd(10'hff, 4'h2, q);
      chk("err beats", q.size(), 34'h2);
      chk("stat beat0", q[0][33:32], 34'h0);
      chk("stat beat1", q[1][33:32], 34'h3);
      i_mmr_host.rd(10'h64, 4'h0, q);
      chk("zero count", q.size(), 34'h1);
      $display("t_err done");
   endtask
   initial begin
      rst = 1'h1;
      n_fail = 0;
      comparisons = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'h0;
      @(negedge clk_sys);
      chk("reset rsp", {waitrequest, rsp}, 34'h0);
      t_rom;
      t_burst;
      t_err;
      report_and_stop;
   end
   // About 35 cycles are needed; 2000 leaves ample margin
   initial begin
      #(5 * 2000);
      n_fail++;
      report_and_stop;
   end
endmodule
`default_nettype wire
